// File: design/dhr_pkg.sv
// Package for the diskette host register bank and drive port.
// Assumes a single 250 MHz clock and an I/O bus decoded on ten address bits.
package dhr_pkg;
	// ----------------------------------------------------------------
	// Register addresses (primary and secondary sets)
	// ----------------------------------------------------------------
	localparam logic [9:0] DHR_PRI_DRIVE_KIND = 10'h3F1; // Drive kind, read.
	localparam logic [9:0] DHR_PRI_OUT_CTRL = 10'h3F2; // Output control, write.
	localparam logic [9:0] DHR_PRI_MAIN_STATUS = 10'h3F4; // Main status.
	localparam logic [9:0] DHR_PRI_DATA = 10'h3F5; // Command data port.
	localparam logic [9:0] DHR_PRI_DIAG_RATE = 10'h3F7; // Diag input read, rate write.
	localparam logic [9:0] DHR_PRI_FIXED = 10'h1F7; // Fixed-disk status.
	localparam logic [9:0] DHR_SEC_DRIVE_KIND = 10'h371;
	localparam logic [9:0] DHR_SEC_OUT_CTRL = 10'h372;
	localparam logic [9:0] DHR_SEC_MAIN_STATUS = 10'h374;
	localparam logic [9:0] DHR_SEC_DATA = 10'h375;
	localparam logic [9:0] DHR_SEC_DIAG_RATE = 10'h377;
	localparam logic [9:0] DHR_SEC_FIXED = 10'h177;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DHR_OC_SEL = 0; // Drive select bit.
	localparam int DHR_OC_RUN = 2; // Controller run (reset when zero).
	localparam int DHR_OC_REQ_EN = 3; // Interrupt and DMA request enable.
	localparam int DHR_OC_MOTOR_A = 4; // Motor A enable.
	localparam int DHR_OC_MOTOR_B = 5; // Motor B enable.
	localparam logic [7:0] DHR_OC_WMASK = 8'h3D; // Writable output control bits.
	localparam logic [7:0] DHR_OC_RESET = 8'h00; // Output control reset value.
	localparam logic [1:0] DHR_RATE_500K = 2'h0; // Bit0=0, bit1=0.
	localparam logic [1:0] DHR_RATE_300K = 2'h1; // Bit0=1, bit1=0.
	localparam logic [1:0] DHR_RATE_250K = 2'h2; // Bit0=0, bit1=1.
	localparam logic [1:0] DHR_RATE_RSVD = 2'h3; // Reserved code.
	localparam logic [7:0] DHR_FIXED_VALUE = 8'h80; // Fixed status, bit 7 forced.
	localparam logic [7:0] DHR_ZERO8 = 8'h00;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int DHR_CLK_MHZ = 250; // System clock rate.
	localparam int DHR_PULSE_8M_NS = 150; // Write pulse at 8 MHz.
	localparam int DHR_PULSE_48M_NS = 208; // Write pulse at 4.8 MHz.
	localparam int DHR_PULSE_4M_NS = 250; // Write pulse at 4 MHz.
	localparam int DHR_PULSE_8M_CYC = (DHR_PULSE_8M_NS * DHR_CLK_MHZ + 999) / 1000;
	localparam int DHR_PULSE_48M_CYC = (DHR_PULSE_48M_NS * DHR_CLK_MHZ + 999) / 1000;
	localparam int DHR_PULSE_4M_CYC = (DHR_PULSE_4M_NS * DHR_CLK_MHZ + 999) / 1000;
	localparam int DHR_SPIN_HD_MS = 1000; // Spin-up wait, high density.
	localparam int DHR_SPIN_DD_MS = 750; // Spin-up wait, double density.
	localparam int DHR_SPIN_HD_CYC = DHR_SPIN_HD_MS * DHR_CLK_MHZ * 1000;
	localparam int DHR_SPIN_DD_CYC = DHR_SPIN_DD_MS * DHR_CLK_MHZ * 1000;
	localparam int DHR_STEP_ACT_US = 5; // Step active time.
	localparam int DHR_STEP_ACT_CYC = DHR_STEP_ACT_US * DHR_CLK_MHZ;
	localparam int DHR_FIFO_DEPTH = 8; // Command FIFO depth.
	// ----------------------------------------------------------------
	// Command engine states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		DHR_IDLE,
		DHR_SPIN,
		DHR_STEP_HI,
		DHR_STEP_LO,
		DHR_WRITE
	} dhr_state_t;
endpackage : dhr_pkg

// File: design/dhr_regs.sv
// Diskette host register bank with drive-side signalling and command FIFO.
// Assumes an I/O bus with active-low strobes from outside the clock domain,
// a DMA address enable, and drive inputs that are asynchronous pins.
//
// Notes on behaviour
// - Head-side output high selects upper head.
// - Write pulses sized by rate, only when gated.
// - Write enable held for whole recording.
// - Step pulse; motion starts at trailing edge.
// - Direction set before stepping: high is outward.
// - Wait spin-up time after motor on.
// - Select active only for addressed drive.
// - Low-current output active for low density.
// - Output control write-only, cleared on reset.
// - Bits 5,4 motors; bit 0 drive select.
// - Bit 2 low holds controller in reset.
// - Bit 3 gates interrupt and DMA requests.
// - Diag input bit 7 is media change.
// - Two-bit rate code selects data rate.
// - Status bits 7..4 report port condition.
// - Status bits 1,0 report drive seeking.
// - Data port presents one stacked byte.
// - Drive kind bits from density inputs.
// - Fixed status reads 0x80 without hard card.
// - Decode documented primary/secondary addresses.
// - Commands arrive as bytes via data port.
// - Group select high picks primary set.
// - No decode while DMA owns the bus.

// ------------------------------------------------------------------
// Command FIFO
// ------------------------------------------------------------------
module dhr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage words.
	logic [AW:0] wr_ptr, rd_ptr; // Write and read pointers, each with a wrap bit.
	logic full, empty; // Occupancy flags.
	assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty = (wr_ptr == rd_ptr);
	assign wr_ready_out = !full;
	assign rd_valid_out = !empty;
	assign rd_data_out = mem[rd_ptr[AW-1:0]];
	// Write side stores a word when accepted.
	always_ff @(posedge clk_in) begin
		if (wr_valid_in && !full) begin
			mem[wr_ptr[AW-1:0]] <= wr_data_in;
		end
	end
	// Pointers advance on each handshake.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (wr_valid_in && !full) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (rd_ready_in && !empty) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule // dhr_fifo

// ------------------------------------------------------------------
// Top level
// ------------------------------------------------------------------
module dhr_regs import dhr_pkg::*; #(
	parameter int SPIN_HD_CYC = DHR_SPIN_HD_CYC,
	parameter int SPIN_DD_CYC = DHR_SPIN_DD_CYC,
	parameter int STEP_CYC = DHR_STEP_ACT_CYC
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [9:0] addr_in,
	input wire logic io_rd_n_in,
	input wire logic io_wr_n_in,
	input wire logic bus_owned_by_dma_in,
	input wire logic group_select_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_n_out,
	input wire logic hard_disk_present_n_in,
	input wire logic density_a_in,
	input wire logic density_b_in,
	input wire logic media_change_in,
	input wire logic [6:0] fixed_diag_in,
	input wire logic read_data_n_in,
	input wire logic protect_n_in,
	input wire logic home_track_n_in,
	input wire logic index_in,
	input wire logic ctrl_irq_in,
	input wire logic ctrl_dma_req_in,
	input wire logic [7:0] result_in,
	input wire logic result_valid_in,
	output logic irq_out,
	output logic dma_req_out,
	output logic head_side_out,
	output logic write_enable_out,
	output logic write_pulse_out,
	output logic step_out,
	output logic direction_out,
	output logic motor_a_out,
	output logic motor_b_out,
	output logic select_a_out,
	output logic select_b_out,
	output logic low_current_out,
	output logic ctrl_reset_out,
	output logic [1:0] rate_out
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [2:0] strb_m; // First stage: read, write, dma enable.
	logic [2:0] strb_s; // Second stage.
	logic [2:0] strb_d; // Delayed copy for edge detection.
	logic [29:0] pin_m; // First stage: diag, data, group, address, densities, hdpres, media.
	logic [29:0] pin_s; // Second stage; bus fields line up in time with the synced strobes.
	// Strobes, bus fields and pins all pass two flops before any logic reads them.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			strb_m <= 3'h7;
			strb_s <= 3'h7;
			strb_d <= 3'h7;
			pin_m <= 30'h0;
			pin_s <= 30'h0;
		end else begin
			strb_m <= {bus_owned_by_dma_in, io_wr_n_in, io_rd_n_in};
			strb_s <= strb_m;
			strb_d <= strb_s;
			pin_m <= {fixed_diag_in, data_in, group_select_in, addr_in,
				density_b_in, density_a_in, hard_disk_present_n_in, media_change_in};
			pin_s <= pin_m;
		end
	end
	logic rd_start, wr_end; // Falling edge of read strobe, rising edge of write strobe.
	assign rd_start = !strb_s[0] && strb_d[0] && !strb_s[2];
	assign wr_end = strb_s[1] && !strb_d[1] && !strb_s[2];
	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Returns true when the address matches the primary copy with grp high, or the secondary copy with grp low.
	function automatic logic hit(input logic [9:0] a, input logic [9:0] p,
		input logic [9:0] s, input logic grp);
		hit = grp ? (a == p) : (a == s);
	endfunction
	logic hit_kind, hit_oc, hit_stat, hit_data, hit_diag, hit_fixed;
	assign hit_kind = hit(pin_s[13:4], DHR_PRI_DRIVE_KIND, DHR_SEC_DRIVE_KIND, pin_s[14]);
	assign hit_oc = hit(pin_s[13:4], DHR_PRI_OUT_CTRL, DHR_SEC_OUT_CTRL, pin_s[14]);
	assign hit_stat = hit(pin_s[13:4], DHR_PRI_MAIN_STATUS, DHR_SEC_MAIN_STATUS, pin_s[14]);
	assign hit_data = hit(pin_s[13:4], DHR_PRI_DATA, DHR_SEC_DATA, pin_s[14]);
	assign hit_diag = hit(pin_s[13:4], DHR_PRI_DIAG_RATE, DHR_SEC_DIAG_RATE, pin_s[14]);
	assign hit_fixed = hit(pin_s[13:4], DHR_PRI_FIXED, DHR_SEC_FIXED, pin_s[14]);
	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	logic [7:0] output_control; // Output control register.
	logic [1:0] rate_select; // Rate code.
	// Output control clears on reset; reserved bits are masked off.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			output_control <= DHR_OC_RESET;
		end else if (wr_end && hit_oc) begin
			output_control <= pin_s[22:15] & DHR_OC_WMASK;
		end
	end
	// Rate register takes the low two bits; other bits are ignored.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rate_select <= DHR_RATE_500K;
		end else if (wr_end && hit_diag) begin
			rate_select <= pin_s[16:15];
		end
	end
	wire logic ctrl_run = output_control[DHR_OC_RUN];
	// ----------------------------------------------------------------
	// Command path: data port writes enter the FIFO
	// ----------------------------------------------------------------
	logic fifo_ready, cmd_valid, cmd_take;
	logic [7:0] cmd_byte;
	dhr_fifo #(.WIDTH(8), .DEPTH(DHR_FIFO_DEPTH)) u_fifo (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in || !ctrl_run),
		.wr_data_in(pin_s[22:15]),
		.wr_valid_in(wr_end && hit_data),
		.wr_ready_out(fifo_ready),
		.rd_data_out(cmd_byte),
		.rd_valid_out(cmd_valid),
		.rd_ready_in(cmd_take)
	);
	// ----------------------------------------------------------------
	// Drive engine: byte bit 7 = write burst, else seek with bits
	// 6 direction, 5 head, 3:0 steps.
	// ----------------------------------------------------------------
	dhr_state_t state;
	logic [31:0] timer; // Delay counter.
	logic [3:0] steps; // Remaining steps.
	logic [7:0] cur; // Current command byte.
	wire logic sel_hd = output_control[DHR_OC_SEL] ? pin_s[3] : pin_s[2]; // Selected drive is HD.
	assign cmd_take = (state == DHR_IDLE) && cmd_valid;
	// Pulse width chosen by the rate code.
	function automatic logic [31:0] pulse_len(input logic [1:0] r);
		unique case (r)
			DHR_RATE_300K: pulse_len = 32'(DHR_PULSE_48M_CYC);
			DHR_RATE_250K: pulse_len = 32'(DHR_PULSE_4M_CYC);
			default: pulse_len = 32'(DHR_PULSE_8M_CYC);
		endcase
	endfunction
	// Sequencer: spin-up wait, then steps or a write burst.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !ctrl_run) begin
			state <= DHR_IDLE;
			timer <= '0;
			steps <= '0;
			cur <= DHR_ZERO8;
		end else begin
			unique case (state)
				DHR_IDLE: begin
					if (cmd_valid) begin
						cur <= cmd_byte;
						steps <= cmd_byte[3:0];
						timer <= sel_hd ? 32'(SPIN_HD_CYC) : 32'(SPIN_DD_CYC);
						state <= DHR_SPIN;
					end
				end
				DHR_SPIN: begin
					if (timer > 32'h1) begin
						timer <= timer - 32'h1;
					end else if (cur[7]) begin
						// One spare cycle keeps the gate up past the full-width pulse.
						timer <= pulse_len(rate_select) + 32'h1;
						state <= DHR_WRITE;
					end else if (steps == 4'h0) begin
						state <= DHR_IDLE;
					end else begin
						timer <= 32'(STEP_CYC);
						state <= DHR_STEP_HI;
					end
				end
				DHR_STEP_HI: begin
					if (timer > 32'h1) begin
						timer <= timer - 32'h1;
					end else begin
						timer <= 32'(STEP_CYC);
						steps <= steps - 4'h1;
						state <= DHR_STEP_LO;
					end
				end
				DHR_STEP_LO: begin
					if (timer > 32'h1) begin
						timer <= timer - 32'h1;
					end else if (steps == 4'h0) begin
						state <= DHR_IDLE;
					end else begin
						timer <= 32'(STEP_CYC);
						state <= DHR_STEP_HI;
					end
				end
				DHR_WRITE: begin
					if (timer > 32'h1) begin
						timer <= timer - 32'h1;
					end else begin
						state <= DHR_IDLE;
					end
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Drive outputs, all registered.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			head_side_out <= 1'b0;
			direction_out <= 1'b0;
			step_out <= 1'b0;
			write_enable_out <= 1'b0;
			write_pulse_out <= 1'b0;
			motor_a_out <= 1'b0;
			motor_b_out <= 1'b0;
			select_a_out <= 1'b0;
			select_b_out <= 1'b0;
			low_current_out <= 1'b0;
			ctrl_reset_out <= 1'b1;
			rate_out <= DHR_RATE_500K;
			irq_out <= 1'b0;
			dma_req_out <= 1'b0;
		end else begin
			head_side_out <= cur[5];
			direction_out <= cur[6];
			step_out <= (state == DHR_STEP_HI);
			write_enable_out <= (state == DHR_WRITE);
			write_pulse_out <= (state == DHR_WRITE) && (timer > 32'h1);
			motor_a_out <= output_control[DHR_OC_MOTOR_A];
			motor_b_out <= output_control[DHR_OC_MOTOR_B];
			select_a_out <= !output_control[DHR_OC_SEL];
			select_b_out <= output_control[DHR_OC_SEL];
			low_current_out <= !sel_hd;
			ctrl_reset_out <= !ctrl_run;
			rate_out <= rate_select;
			irq_out <= output_control[DHR_OC_REQ_EN] && ctrl_irq_in;
			dma_req_out <= output_control[DHR_OC_REQ_EN] && ctrl_dma_req_in;
		end
	end
	// ----------------------------------------------------------------
	// Result byte and read mux
	// ----------------------------------------------------------------
	logic [7:0] result_byte; // One result byte presented at a time.
	logic result_full;
	// Result byte holds until the host reads it; a new one wins a same-cycle read.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			result_byte <= DHR_ZERO8;
			result_full <= 1'b0;
		end else if (result_valid_in) begin
			result_byte <= result_in;
			result_full <= 1'b1;
		end else if (rd_start && hit_data) begin
			result_full <= 1'b0;
		end
	end
	wire logic [7:0] main_status = {result_full || fifo_ready, result_full,
		!output_control[DHR_OC_REQ_EN], state == DHR_WRITE, 2'b00,
		(state != DHR_IDLE) && !cur[7] && output_control[DHR_OC_SEL],
		(state != DHR_IDLE) && !cur[7] && !output_control[DHR_OC_SEL]};
	// Read data is latched at the strobe edge and driven until it rises.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			data_out <= DHR_ZERO8;
			data_oe_n_out <= 1'b1;
		end else if (rd_start) begin
			data_oe_n_out <= 1'b0;
			if (hit_kind) begin
				data_out <= {6'h00, pin_s[3], pin_s[2]};
			end else if (hit_stat) begin
				data_out <= main_status;
			end else if (hit_data) begin
				data_out <= result_byte;
			end else if (hit_diag) begin
				data_out <= {pin_s[0], pin_s[29:23]};
			end else if (hit_fixed && pin_s[1]) begin
				data_out <= DHR_FIXED_VALUE;
			end else begin
				data_oe_n_out <= 1'b1;
			end
		end else if (strb_s[0]) begin
			data_oe_n_out <= 1'b1;
		end
	end
endmodule // dhr_regs

// File: sim/dhr_regs_props.sv
// Checker for the diskette register bank: drive-side and bus-answer relations.
// Assumes it is bound onto dhr_regs and that the bench sets STEP_CYC to 4.
module dhr_regs_props #(
	parameter int STEP_CYC = 4
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic io_rd_n_in,
	input wire logic bus_owned_by_dma_in,
	input wire logic ctrl_irq_in,
	input wire logic ctrl_dma_req_in,
	input wire logic data_oe_n_out,
	input wire logic irq_out,
	input wire logic dma_req_out,
	input wire logic write_enable_out,
	input wire logic write_pulse_out,
	input wire logic step_out,
	input wire logic direction_out,
	input wire logic motor_a_out,
	input wire logic motor_b_out,
	input wire logic select_a_out,
	input wire logic select_b_out,
	input wire logic ctrl_reset_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	chk_irq_gated: assert property (irq_out |-> $past(ctrl_irq_in))
		else $error("interrupt without a core request");
	chk_dma_gated: assert property (dma_req_out |-> $past(ctrl_dma_req_in))
		else $error("DMA request without a core request");
	chk_one_select: assert property (select_a_out |-> !select_b_out)
		else $error("both drives selected");
	chk_pulse_gated: assert property (write_pulse_out |-> write_enable_out)
		else $error("write pulse outside write gate");
	chk_dir_steady: assert property (step_out |-> $stable(direction_out))
		else $error("direction moved during a step");
	// The repetition count equals STEP_CYC as the bench sets it.
	chk_step_width: assert property ($rose(step_out) |-> step_out[*4] ##1 !step_out)
		else $error("step pulse width wrong");
	chk_reset_state: assert property ($fell(sys_rst_in) |->
		ctrl_reset_out && !motor_a_out && !motor_b_out && !irq_out ##1 select_a_out)
		else $error("output control not cleared by reset");
	chk_oe_cause: assert property ($fell(data_oe_n_out) |-> !$past(io_rd_n_in, 2))
		else $error("bus driven without a read strobe");
	chk_dma_quiet: assert property ($fell(data_oe_n_out) |->
		!($past(bus_owned_by_dma_in, 2) && $past(bus_owned_by_dma_in, 3)))
		else $error("answered while DMA owns the bus");
	cov_write: cover property ($rose(write_pulse_out));
	cov_step: cover property ($rose(step_out));
	cov_irq: cover property ($rose(irq_out));
endmodule // dhr_regs_props

bind dhr_regs dhr_regs_props #(.STEP_CYC(STEP_CYC)) u_props (.clk_in, .sys_rst_in,
	.io_rd_n_in, .bus_owned_by_dma_in, .ctrl_irq_in, .ctrl_dma_req_in, .data_oe_n_out,
	.irq_out, .dma_req_out, .write_enable_out, .write_pulse_out, .step_out,
	.direction_out, .motor_a_out, .motor_b_out, .select_a_out, .select_b_out,
	.ctrl_reset_out);

// File: sim/dhr_host_model.sv
// Host processor model: slow I/O strobes on the register bus.
// Assumes the bench calls its tasks; strobes are held well past the sync delay.
module dhr_host_model (
	input wire logic clk_in,
	output logic [9:0] addr_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic [7:0] wdata_out,
	input wire logic [7:0] rdata_in,
	input wire logic oe_n_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus: no strobe active at time zero.
	initial begin
		addr_out = 10'h000;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		wdata_out = 8'h00;
	end
	// One byte write; data held past the commit, then scrambled six cycles after release.
	task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_n_out <= 1'b0;
		repeat (5) @(posedge clk_in);
		wr_n_out <= 1'b1;
		repeat (6) @(posedge clk_in);
		wdata_out <= ~d;
	endtask
	// One read; the strobe stays low for eight cycles, data taken at first answer.
	task automatic io_rd(input logic [9:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge clk_in);
		addr_out <= a;
		rd_n_out <= 1'b0;
		for (int n = 0; n < 8; n++) begin
			@(posedge clk_in);
			if (!ok && oe_n_in === 1'b0) begin
				ok = 1'b1;
				d = rdata_in;
			end
		end
		rd_n_out <= 1'b1;
		repeat (6) @(posedge clk_in);
	endtask
endmodule // dhr_host_model

// File: sim/tb_top.sv
// Self-checking bench for the diskette register bank and drive port.
// Assumes the host model and checker files are compiled before this one.
module tb_top import dhr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic bus_owned_by_dma_in = 1'b0;
	logic group_select_in = 1'b1;
	logic hard_disk_present_n_in = 1'b1;
	logic density_a_in = 1'b1;
	logic density_b_in = 1'b0;
	logic media_change_in = 1'b1;
	logic read_data_n_in = 1'b1;
	logic protect_n_in = 1'b1;
	logic [6:0] fixed_diag_in = 7'h2A;
	logic ctrl_irq_in = 1'b0;
	logic ctrl_dma_req_in = 1'b0;
	logic [7:0] result_in = 8'h00;
	logic result_valid_in = 1'b0;
	logic [9:0] addr_in;
	logic io_rd_n_in, io_wr_n_in, data_oe_n_out, irq_out, dma_req_out, head_side_out;
	logic write_enable_out, write_pulse_out, step_out, direction_out, motor_a_out;
	logic motor_b_out, select_a_out, select_b_out, low_current_out, ctrl_reset_out;
	logic [7:0] data_in, data_out;
	logic [1:0] rate_out;
	int n_mismatch = 0;
	int total_checks = 0;
	always #2 clk_in = ~clk_in;
	dhr_host_model u_host (.clk_in, .addr_out(addr_in), .rd_n_out(io_rd_n_in),
		.wr_n_out(io_wr_n_in), .wdata_out(data_in), .rdata_in(data_out),
		.oe_n_in(data_oe_n_out));
	dhr_regs #(.SPIN_HD_CYC(20), .SPIN_DD_CYC(20), .STEP_CYC(4)) u_dut (.clk_in, .sys_rst_in,
		.addr_in, .io_rd_n_in, .io_wr_n_in, .bus_owned_by_dma_in, .group_select_in, .data_in,
		.data_out, .data_oe_n_out, .hard_disk_present_n_in, .density_a_in, .density_b_in,
		.media_change_in, .fixed_diag_in,
		.read_data_n_in,
		.protect_n_in,
		.home_track_n_in(1'b1),
		.index_in(1'b0),
		.ctrl_irq_in, .ctrl_dma_req_in, .result_in, .result_valid_in, .irq_out, .dma_req_out,
		.head_side_out, .write_enable_out, .write_pulse_out, .step_out, .direction_out,
		.motor_a_out, .motor_b_out, .select_a_out, .select_b_out, .low_current_out,
		.ctrl_reset_out, .rate_out);
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Read one address; an unanswered read must stay refused.
	task automatic rd_exp(input logic [9:0] a, input logic [7:0] exp, input logic ok_exp);
		logic [7:0] d;
		logic ok;
		u_host.io_rd(a, d, ok);
		cmp_byte({7'h00, ok}, {7'h00, ok_exp}, "answer");
		if (ok_exp) cmp_byte(d, exp, "read data");
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		repeat (2) @(posedge clk_in);
		cmp_byte({3'h0, ctrl_reset_out, motor_b_out, motor_a_out, select_b_out, select_a_out},
			8'h11, "reset state");
		rd_exp(DHR_PRI_MAIN_STATUS, 8'hA0, 1'b1);
	endtask
	task automatic t_oc();
		u_host.io_wr(DHR_PRI_OUT_CTRL, 8'hF1);
		cmp_byte({3'h0, ctrl_reset_out, motor_b_out, motor_a_out, select_b_out, select_a_out},
			8'h1E, "motors and select");
		rd_exp(DHR_PRI_OUT_CTRL, 8'h00, 1'b0);
		ctrl_irq_in <= 1'b1;
		ctrl_dma_req_in <= 1'b1;
		u_host.io_wr(DHR_PRI_OUT_CTRL, 8'h0C);
		cmp_byte({4'h0, irq_out, dma_req_out, ctrl_reset_out, select_a_out}, 8'h0D, "on");
		u_host.io_wr(DHR_PRI_OUT_CTRL, 8'h04);
		cmp_byte({4'h0, irq_out, dma_req_out, ctrl_reset_out, select_a_out}, 8'h01, "off");
	endtask
	task automatic t_reads();
		rd_exp(DHR_PRI_DRIVE_KIND, 8'h01, 1'b1);
		rd_exp(DHR_PRI_DIAG_RATE, 8'hAA, 1'b1);
		rd_exp(DHR_PRI_FIXED, 8'h80, 1'b1);
		rd_exp(10'h3F0, 8'h00, 1'b0);
		hard_disk_present_n_in <= 1'b0;
		group_select_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rd_exp(DHR_SEC_FIXED, 8'h00, 1'b0);
		rd_exp(DHR_SEC_DRIVE_KIND, 8'h01, 1'b1);
		rd_exp(DHR_PRI_DRIVE_KIND, 8'h00, 1'b0);
		group_select_in <= 1'b1;
		bus_owned_by_dma_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		rd_exp(DHR_PRI_DRIVE_KIND, 8'h00, 1'b0);
		bus_owned_by_dma_in <= 1'b0;
		result_in <= 8'h5A;
		result_valid_in <= 1'b1;
		@(posedge clk_in);
		result_valid_in <= 1'b0;
		rd_exp(DHR_PRI_MAIN_STATUS, 8'hE0, 1'b1);
		rd_exp(DHR_PRI_DATA, 8'h5A, 1'b1);
		rd_exp(DHR_PRI_MAIN_STATUS, 8'hA0, 1'b1);
	endtask
	// Each rate code in turn, each followed by one write burst whose pulse width is measured.
	task automatic t_rate();
		int exp_w [4] = '{DHR_PULSE_8M_CYC, DHR_PULSE_48M_CYC, DHR_PULSE_4M_CYC, DHR_PULSE_8M_CYC};
		int n;
		u_host.io_wr(DHR_PRI_OUT_CTRL, 8'h1C);
		for (int c = 0; c < 4; c++) begin
			u_host.io_wr(DHR_PRI_DIAG_RATE, {6'h3F, c[1:0]});
			cmp_byte({6'h00, rate_out}, {6'h00, c[1:0]}, "rate");
			u_host.io_wr(DHR_PRI_DATA, 8'h80);
			n = 0;
			for (int t = 0; t < 200 && write_pulse_out !== 1'b1; t++) @(posedge clk_in);
			while (write_pulse_out === 1'b1 && n < 100) begin
				cmp_byte({7'h00, write_enable_out}, 8'h01, "gate");
				n++;
				@(posedge clk_in);
			end
			cmp_byte(n[7:0], exp_w[c][7:0], "pulse width");
		end
	endtask
	// A seek of cmd[3:0] steps, with the seeking drive read back mid-way.
	task automatic t_seek(input logic [7:0] oc, input logic [7:0] cmd, input logic [7:0] st,
		input logic lc);
		int steps;
		steps = 0;
		u_host.io_wr(DHR_PRI_OUT_CTRL, oc);
		fork
			forever @(posedge step_out) steps++;
		join_none
		u_host.io_wr(DHR_PRI_DATA, cmd);
		repeat (16) @(posedge clk_in);
		cmp_byte(steps[7:0], 8'h00, "spin wait");
		repeat (8) @(posedge clk_in);
		rd_exp(DHR_PRI_MAIN_STATUS, st, 1'b1);
		repeat (300) @(posedge clk_in);
		disable fork;
		cmp_byte(steps[7:0], {4'h0, cmd[3:0]}, "steps");
		cmp_byte({5'h00, direction_out, head_side_out, low_current_out},
			{5'h00, cmd[6], cmd[5], lc}, "drive lines");
	endtask
	// Overfill the command buffer, then flush it through the controller reset bit.
	task automatic t_fifo();
		logic [7:0] d;
		logic ok;
		repeat (12) u_host.io_wr(DHR_PRI_DATA, 8'h4F);
		u_host.io_rd(DHR_PRI_MAIN_STATUS, d, ok);
		cmp_byte({7'h00, d[7]}, 8'h00, "full");
		u_host.io_wr(DHR_PRI_OUT_CTRL, 8'h18);
		u_host.io_rd(DHR_PRI_MAIN_STATUS, d, ok);
		cmp_byte({7'h00, d[7]}, 8'h01, "flushed");
	endtask
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		t_reset();
		t_oc();
		t_reads();
		t_rate();
		t_seek(8'h1C, 8'h48, 8'h81, 1'b0);
		t_seek(8'h1C, 8'h28, 8'h81, 1'b0);
		t_seek(8'h2D, 8'h68, 8'h82, 1'b1);
		t_fifo();
		tally_and_finish();
	end
	// The tests take about 1900 cycles; the 25000-cycle limit gives them about thirteen times that.
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule // tb_top
